// ==== verilog/pm_trap_pkg.sv ====
// Constants and types for the power-management trap and status register slice.
//
// Notes on behaviour
// - Control bit 7 picks I/O or memory decode.
// - I/O mode: bit 6 enables write tracking.
// - I/O mode: bit 5 enables read tracking.
// - I/O mode: bits 4:0 mask A[4:0].
// - Memory mode: bits 6:0 mask A[15:9].
// - Mask bit one ignores that address bit.
// - A software trigger write with byte 0 enabled raises interrupt.
// - Status 1 bit 4 flags game port access.
// - Game read and write have separate enables.
// - Status 1 bits 3:0 flag pin transitions.
// - Pin counts only if enabled, input, armed.
// - Reading status register returns then clears bits.
// - Mirror index reads status without clearing.
// - Status 2 bits flag idle timer expiry.
// - Status 3 bit 7 flags video trap.
// - Any status bit feeds the top-level summary.
// - Each user device has 32-bit base address.
package pm_trap_pkg;

	// ---------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ---------------------------------------------------------------
	localparam logic [7:0] IDX_UDEV1_BASE   = 8'hc0;
	localparam logic [7:0] IDX_UDEV2_BASE   = 8'hc4;
	localparam logic [7:0] IDX_UDEV3_BASE   = 8'hc8;
	localparam logic [7:0] IDX_UDEV1_CTRL   = 8'hcc;
	localparam logic [7:0] IDX_UDEV2_CTRL   = 8'hcd;
	localparam logic [7:0] IDX_UDEV3_CTRL   = 8'hce;
	localparam logic [7:0] IDX_SW_TRIGGER   = 8'hd0;
	localparam logic [7:0] IDX_GAME_ENABLE  = 8'hd1;
	localparam logic [7:0] IDX_GPIO_CONFIG  = 8'hd2;
	localparam logic [7:0] IDX_TIMER_TEST   = 8'hec;
	localparam logic [7:0] IDX_STAT1_MIRROR = 8'h84;
	localparam logic [7:0] IDX_STAT2_MIRROR = 8'h85;
	localparam logic [7:0] IDX_STAT3_MIRROR = 8'h86;
	localparam logic [7:0] IDX_STAT1        = 8'hf4;
	localparam logic [7:0] IDX_STAT2        = 8'hf5;
	localparam logic [7:0] IDX_STAT3        = 8'hf6;

	// ---------------------------------------------------------------
	// Field positions and reset values
	// ---------------------------------------------------------------
	localparam int          CTRL_MEM_BIT   = 7;
	localparam int          CTRL_WR_BIT    = 6;
	localparam int          CTRL_RD_BIT    = 5;
	localparam int          STAT1_GAME_BIT = 4;
	localparam int          STAT3_VID_BIT  = 7;
	localparam int          GAME_RD_EN_BIT = 0;
	localparam int          GAME_WR_EN_BIT = 1;
	localparam logic [7:0]  RST_BYTE       = 8'h00;
	localparam logic [31:0] RST_WORD       = 32'h0000_0000;
	localparam logic [31:0] UNMAPPED_DATA  = 32'h0000_0000;
	localparam logic [15:0] GAME_PORT_BASE = 16'h0200;
	localparam int          PIN_SYNC_LEN   = 3;

	// One snooped host bus cycle, presented for one clock.
	typedef struct packed {
		logic        valid;
		logic        is_mem;
		logic        is_write;
		logic [31:0] addr;
	} snoop_cycle_t;

	// Per-pin general-purpose configuration.
	typedef struct packed {
		logic [3:0] is_gpio;
		logic [3:0] is_input;
		logic [3:0] irq_en;
	} gpio_cfg_t;

endpackage

// ==== verilog/pm_trap_and_smi_status.sv ====
// Trap decode and read-to-clear management interrupt status register slice.
`timescale 1ns/1ps

module pm_trap_and_smi_status
	import pm_trap_pkg::*;
(
	// Clock and reset
	input  wire logic         core_clk_i,
	input  wire logic         rst_i,
	// Avalon-MM slave
	input  wire logic [9:0]   avs_address_i,
	input  wire logic         avs_read_i,
	input  wire logic         avs_write_i,
	input  wire logic [31:0]  avs_writedata_i,
	input  wire logic [3:0]   avs_byteenable_i,
	output logic [31:0]       avs_readdata_o,
	output logic              avs_waitrequest_o,
	// Snooped host bus cycles
	input  wire snoop_cycle_t snoop_i,
	// Event sources
	input  wire logic [7:0]   idle_expire_i,
	input  wire logic         video_trap_i,
	input  wire logic [3:0]   gpio_pin_i,
	// Results
	output logic [2:0]        udev_hit_o,
	output logic              mgmt_interrupt_o,
	output logic              sw_trigger_pulse_o,
	output logic              status_summary_o,
	output logic [7:0]        timer_test_value_o
);

	// ---------------------------------------------------------------
	// Address matching
	// ---------------------------------------------------------------
	function automatic logic addr_match(input logic [31:0] base, input logic [7:0] ctl,
		input snoop_cycle_t c);
		logic [31:0] care;
		care = 32'hffff_ffff;
		if (ctl[CTRL_MEM_BIT]) begin
			care[15:9] = ~ctl[6:0];
			care[8:0]  = 9'h000;
		end else begin
			care[4:0] = ~ctl[4:0];
		end
		addr_match = ((c.addr & care) == (base & care));
	endfunction

	function automatic logic tracked(input logic [7:0] ctl, input snoop_cycle_t c);
		if (!c.valid || (c.is_mem != ctl[CTRL_MEM_BIT])) begin
			tracked = 1'b0;
		end else if (ctl[CTRL_MEM_BIT]) begin
			tracked = 1'b1;
		end else begin
			tracked = c.is_write ? ctl[CTRL_WR_BIT] : ctl[CTRL_RD_BIT];
		end
	endfunction

	function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [31:0] d,
		input logic [3:0] be);
		merge_byte = be[0] ? d[7:0] : old;
	endfunction

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	logic [31:0] base_r   [3];
	logic [7:0]  ctrl_r   [3];
	logic [7:0]  timer_r;
	logic [1:0]  game_en_r;
	gpio_cfg_t   gpio_cfg_r;
	logic [7:0]  stat1_r;
	logic [7:0]  stat2_r;
	logic [7:0]  stat3_r;
	logic        sw_pulse_r;
	logic [2:0]  hit_r;
	logic        ack_r;
	logic [31:0] rdata_r;
	logic [PIN_SYNC_LEN-1:0] sync_r [4];
	logic [3:0]  pin_state_r;

	// Every access takes one wait cycle, then completes.
	wire        req      = avs_read_i | avs_write_i;
	wire        done     = req & ack_r;
	wire [7:0]  idx      = avs_address_i[9:2];
	wire        wr_fire  = avs_write_i & done;
	wire        rd_fire  = avs_read_i & done;
	wire        rd_stat1 = rd_fire & (idx == IDX_STAT1);
	wire        rd_stat2 = rd_fire & (idx == IDX_STAT2);
	wire        rd_stat3 = rd_fire & (idx == IDX_STAT3);
	wire        wr_sw    = wr_fire & (idx == IDX_SW_TRIGGER) & avs_byteenable_i[0];
	wire [2:0]  wr_base  = {3{wr_fire}} & {idx == IDX_UDEV3_BASE, idx == IDX_UDEV2_BASE,
		idx == IDX_UDEV1_BASE};
	wire [2:0]  wr_ctrl  = {3{wr_fire}} & {idx == IDX_UDEV3_CTRL, idx == IDX_UDEV2_CTRL,
		idx == IDX_UDEV1_CTRL};
	wire        wr_timer = wr_fire & (idx == IDX_TIMER_TEST);
	wire        wr_game  = wr_fire & (idx == IDX_GAME_ENABLE) & avs_byteenable_i[0];
	wire        wr_gpio  = wr_fire & (idx == IDX_GPIO_CONFIG) & avs_byteenable_i[0];

	assign avs_waitrequest_o = req & ~ack_r;

	// ---------------------------------------------------------------
	// Event detection
	// ---------------------------------------------------------------
	logic [2:0] hit_nxt;
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			hit_nxt[i] = tracked(ctrl_r[i], snoop_i) & addr_match(base_r[i], ctrl_r[i], snoop_i);
		end
	end

	wire game_addr = snoop_i.valid & ~snoop_i.is_mem
		& (snoop_i.addr[15:1] == GAME_PORT_BASE[15:1]);
	wire game_evt  = game_addr & (snoop_i.is_write ? game_en_r[GAME_WR_EN_BIT]
		: game_en_r[GAME_RD_EN_BIT]);

	// A pin change is seen once the second and third stages agree on a new level.
	logic [3:0] pin_agree;
	logic [3:0] pin_new;
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			pin_agree[i] = sync_r[i][1] == sync_r[i][2];
			pin_new[i]   = sync_r[i][1];
		end
	end
	wire [3:0] pin_edge = pin_agree & (pin_new ^ pin_state_r);
	wire [3:0] gpio_evt = pin_edge & gpio_cfg_r.is_gpio & gpio_cfg_r.is_input
		& gpio_cfg_r.irq_en;

	// Sets win over the read clear so no event is lost. A read clears only the bits
	// that it returned: a bit that lands during the wait cycle was not seen by software
	// and must survive for the next read.
	wire [7:0] stat1_clr = rd_stat1 ? rdata_r[7:0] : 8'h00;
	wire [7:0] stat2_clr = rd_stat2 ? rdata_r[7:0] : 8'h00;
	wire [7:0] stat3_clr = rd_stat3 ? rdata_r[7:0] : 8'h00;
	wire [7:0] stat1_set = {3'b000, game_evt, gpio_evt};
	wire [7:0] stat1_nxt = (stat1_r & ~stat1_clr) | stat1_set;
	wire [7:0] stat2_nxt = (stat2_r & ~stat2_clr) | idle_expire_i;
	wire [7:0] stat3_nxt = (stat3_r & ~stat3_clr)
		| {video_trap_i, 7'h00};

	// ---------------------------------------------------------------
	// Read data selection
	// ---------------------------------------------------------------
	logic [31:0] rmux;
	always_comb begin
		case (idx)
			IDX_UDEV1_BASE:                  rmux = base_r[0];
			IDX_UDEV2_BASE:                  rmux = base_r[1];
			IDX_UDEV3_BASE:                  rmux = base_r[2];
			IDX_UDEV1_CTRL:                  rmux = {24'h0, ctrl_r[0]};
			IDX_UDEV2_CTRL:                  rmux = {24'h0, ctrl_r[1]};
			IDX_UDEV3_CTRL:                  rmux = {24'h0, ctrl_r[2]};
			IDX_GAME_ENABLE:                 rmux = {30'h0, game_en_r};
			IDX_GPIO_CONFIG:                 rmux = {20'h0, gpio_cfg_r};
			IDX_TIMER_TEST:                  rmux = {24'h0, timer_r};
			IDX_STAT1, IDX_STAT1_MIRROR:     rmux = {24'h0, stat1_r};
			IDX_STAT2, IDX_STAT2_MIRROR:     rmux = {24'h0, stat2_r};
			IDX_STAT3, IDX_STAT3_MIRROR:     rmux = {24'h0, stat3_r};
			default:                         rmux = UNMAPPED_DATA;
		endcase
	end

	// ---------------------------------------------------------------
	// Sequential logic
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ack_r   <= 1'b0;
			rdata_r <= RST_WORD;
		end else begin
			ack_r   <= req & ~ack_r;
			rdata_r <= (avs_read_i & ~ack_r) ? rmux : rdata_r;
		end
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < 3; i++) begin
				base_r[i] <= RST_WORD;
				ctrl_r[i] <= RST_BYTE;
			end
			timer_r    <= RST_BYTE;
			game_en_r  <= 2'b00;
			gpio_cfg_r <= '0;
		end else begin
			for (int i = 0; i < 3; i++) begin
				for (int b = 0; b < 4; b++) begin
					if (wr_base[i] && avs_byteenable_i[b]) begin
						base_r[i][8*b +: 8] <= avs_writedata_i[8*b +: 8];
					end
				end
				if (wr_ctrl[i]) begin
					ctrl_r[i] <= merge_byte(ctrl_r[i], avs_writedata_i, avs_byteenable_i);
				end
			end
			if (wr_timer) begin
				timer_r <= merge_byte(timer_r, avs_writedata_i, avs_byteenable_i);
			end
			if (wr_game) begin
				game_en_r <= avs_writedata_i[1:0];
			end
			if (wr_gpio) begin
				gpio_cfg_r <= avs_writedata_i[11:0];
			end
		end
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			stat1_r     <= RST_BYTE;
			stat2_r     <= RST_BYTE;
			stat3_r     <= RST_BYTE;
			sw_pulse_r  <= 1'b0;
			hit_r       <= 3'b000;
			pin_state_r <= 4'h0;
			for (int i = 0; i < 4; i++) begin
				sync_r[i] <= '0;
			end
		end else begin
			stat1_r    <= stat1_nxt;
			stat2_r    <= stat2_nxt;
			stat3_r    <= stat3_nxt;
			sw_pulse_r <= wr_sw;
			hit_r      <= hit_nxt;
			for (int i = 0; i < 4; i++) begin
				sync_r[i] <= {sync_r[i][1:0], gpio_pin_i[i]};
				if (pin_agree[i]) begin
					pin_state_r[i] <= pin_new[i];
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	wire summary = |{stat1_r, stat2_r, stat3_r};
	assign avs_readdata_o     = rdata_r;
	assign udev_hit_o         = hit_r;
	assign sw_trigger_pulse_o = sw_pulse_r;
	assign status_summary_o   = summary;
	assign mgmt_interrupt_o   = summary | sw_pulse_r;
	assign timer_test_value_o = timer_r;

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	a_sw_write_pulse: assert property (@(posedge core_clk_i) disable iff (rst_i)
		wr_sw |=> sw_trigger_pulse_o && mgmt_interrupt_o)
		else $error("software trigger write gave no interrupt");
	a_stat1_clear: assert property (@(posedge core_clk_i) disable iff (rst_i)
		rd_stat1 && stat1_set == 8'h00
		|=> stat1_r == ($past(stat1_r) & ~$past(avs_readdata_o[7:0])))
		else $error("status 1 not cleared by read");
	a_mirror_keeps: assert property (@(posedge core_clk_i) disable iff (rst_i)
		rd_fire && idx == IDX_STAT2_MIRROR |=> (stat2_r & $past(stat2_r)) == $past(stat2_r))
		else $error("mirror read cleared idle status");
	a_idle_sets: assert property (@(posedge core_clk_i) disable iff (rst_i)
		idle_expire_i[7] |=> stat2_r[7])
		else $error("idle expiry not recorded");
	a_video_sets: assert property (@(posedge core_clk_i) disable iff (rst_i)
		video_trap_i |=> stat3_r[STAT3_VID_BIT] ##0 status_summary_o)
		else $error("video trap not recorded");
	a_game_gated: assert property (@(posedge core_clk_i) disable iff (rst_i)
		game_addr && !snoop_i.is_write && !game_en_r[GAME_RD_EN_BIT] && !rd_stat1
		&& !stat1_r[STAT1_GAME_BIT] |=> !stat1_r[STAT1_GAME_BIT])
		else $error("disabled game read set status");
	a_hit_mem_mode: assert property (@(posedge core_clk_i) disable iff (rst_i)
		snoop_i.valid && snoop_i.is_mem && ctrl_r[0][CTRL_MEM_BIT]
		&& snoop_i.addr[31:16] == base_r[0][31:16] && ctrl_r[0][6:0] == 7'h7f
		|=> udev_hit_o[0])
		else $error("memory window hit missed");
	a_hit_io_wr_off: assert property (@(posedge core_clk_i) disable iff (rst_i)
		snoop_i.valid && snoop_i.is_write && !ctrl_r[1][CTRL_MEM_BIT]
		&& !ctrl_r[1][CTRL_WR_BIT] |=> !udev_hit_o[1])
		else $error("untracked write hit");
	a_gpio_gated: assert property (@(posedge core_clk_i) disable iff (rst_i)
		!gpio_cfg_r.irq_en[0] && !stat1_r[0] && !rd_stat1 |=> !stat1_r[0])
		else $error("unarmed pin set status");
	a_wait_once: assert property (@(posedge core_clk_i) disable iff (rst_i)
		req && !ack_r |=> !avs_waitrequest_o)
		else $error("waitrequest held too long");
	a_rd_data_holds: assert property (@(posedge core_clk_i) disable iff (rst_i)
		!avs_read_i |=> $stable(avs_readdata_o))
		else $error("read data changed without a read");
	a_reset_clear: assert property (@(posedge core_clk_i)
		$fell(rst_i) |-> timer_test_value_o == RST_BYTE && !mgmt_interrupt_o
		&& udev_hit_o == 3'b000 && avs_readdata_o == RST_WORD)
		else $error("outputs not cleared by reset");

	// Snooped cycle decode against each device's base and mask.
	a_mem_skips_io: assert property (@(posedge core_clk_i) disable iff (rst_i)
		snoop_i.valid && !snoop_i.is_mem && ctrl_r[0][CTRL_MEM_BIT] |=> !udev_hit_o[0])
		else $error("memory device hit on an I/O cycle");
	a_io_skips_mem: assert property (@(posedge core_clk_i) disable iff (rst_i)
		snoop_i.valid && snoop_i.is_mem && !ctrl_r[2][CTRL_MEM_BIT] |=> !udev_hit_o[2])
		else $error("I/O device hit on a memory cycle");
	a_io_wr_hit: assert property (@(posedge core_clk_i) disable iff (rst_i)
		snoop_i.valid && !snoop_i.is_mem && snoop_i.is_write && ctrl_r[0][7:6] == 2'b01
		&& snoop_i.addr == base_r[0] |=> udev_hit_o[0])
		else $error("tracked write missed");
	a_io_rd_off: assert property (@(posedge core_clk_i) disable iff (rst_i)
		snoop_i.valid && !snoop_i.is_write && !ctrl_r[0][CTRL_MEM_BIT]
		&& !ctrl_r[0][CTRL_RD_BIT] |=> !udev_hit_o[0])
		else $error("untracked read hit");
	a_io_mask_hit: assert property (@(posedge core_clk_i) disable iff (rst_i)
		snoop_i.valid && !snoop_i.is_mem && snoop_i.is_write && ctrl_r[2][7:6] == 2'b01
		&& snoop_i.addr[31:5] == base_r[2][31:5]
		&& ((snoop_i.addr[4:0] ^ base_r[2][4:0]) & ~ctrl_r[2][4:0]) == 5'h00
		|=> udev_hit_o[2])
		else $error("masked I/O address missed");
	a_io_care_miss: assert property (@(posedge core_clk_i) disable iff (rst_i)
		snoop_i.valid && !ctrl_r[1][CTRL_MEM_BIT]
		&& ((snoop_i.addr[4:0] ^ base_r[1][4:0]) & ~ctrl_r[1][4:0]) != 5'h00
		|=> !udev_hit_o[1])
		else $error("unmasked I/O address bit ignored");
	a_mem_low_free: assert property (@(posedge core_clk_i) disable iff (rst_i)
		snoop_i.valid && snoop_i.is_mem && ctrl_r[2][CTRL_MEM_BIT]
		&& snoop_i.addr[31:9] == base_r[2][31:9] && ctrl_r[2][6:0] == 7'h00
		|=> udev_hit_o[2])
		else $error("memory low address bits not ignored");
	a_mem_high_miss: assert property (@(posedge core_clk_i) disable iff (rst_i)
		snoop_i.valid && ctrl_r[0][CTRL_MEM_BIT]
		&& snoop_i.addr[31:16] != base_r[0][31:16] |=> !udev_hit_o[0])
		else $error("memory base upper bits not compared");
	a_io_high_miss: assert property (@(posedge core_clk_i) disable iff (rst_i)
		snoop_i.valid && !ctrl_r[2][CTRL_MEM_BIT]
		&& snoop_i.addr[31:5] != base_r[2][31:5] |=> !udev_hit_o[2])
		else $error("I/O base upper bits not compared");
	a_hit_one_cycle: assert property (@(posedge core_clk_i) disable iff (rst_i)
		!snoop_i.valid |=> udev_hit_o == 3'b000)
		else $error("hit without a snooped cycle");

	// Status recording, mirrors and read clearing.
	a_game_sets: assert property (@(posedge core_clk_i) disable iff (rst_i)
		game_evt |=> stat1_r[STAT1_GAME_BIT])
		else $error("game port access not recorded");
	a_game_wr_gated: assert property (@(posedge core_clk_i) disable iff (rst_i)
		game_addr && snoop_i.is_write && !game_en_r[GAME_WR_EN_BIT]
		&& !stat1_r[STAT1_GAME_BIT] |=> !stat1_r[STAT1_GAME_BIT])
		else $error("disabled game write set status");
	a_gpio_sets: assert property (@(posedge core_clk_i) disable iff (rst_i)
		gpio_evt[3] |=> stat1_r[3])
		else $error("pin transition not recorded");
	a_gpio_input_only: assert property (@(posedge core_clk_i) disable iff (rst_i)
		!gpio_cfg_r.is_input[2] && !stat1_r[2] |=> !stat1_r[2])
		else $error("output pin set status");
	a_gpio_is_gpio: assert property (@(posedge core_clk_i) disable iff (rst_i)
		!gpio_cfg_r.is_gpio[1] && !stat1_r[1] |=> !stat1_r[1])
		else $error("non general-purpose pin set status");
	a_mirror_stat1: assert property (@(posedge core_clk_i) disable iff (rst_i)
		rd_fire && idx == IDX_STAT1_MIRROR |=> (stat1_r & $past(stat1_r)) == $past(stat1_r))
		else $error("mirror read cleared pin status");
	a_mirror_stat3: assert property (@(posedge core_clk_i) disable iff (rst_i)
		rd_fire && idx == IDX_STAT3_MIRROR |=> (stat3_r & $past(stat3_r)) == $past(stat3_r))
		else $error("mirror read cleared trap status");
	a_stat2_clear: assert property (@(posedge core_clk_i) disable iff (rst_i)
		rd_stat2 && idle_expire_i == 8'h00
		|=> stat2_r == ($past(stat2_r) & ~$past(avs_readdata_o[7:0])))
		else $error("status 2 not cleared by read");
	a_stat3_clear: assert property (@(posedge core_clk_i) disable iff (rst_i)
		rd_stat3 && !video_trap_i
		|=> stat3_r == ($past(stat3_r) & ~$past(avs_readdata_o[7:0])))
		else $error("status 3 not cleared by read");

	// Interrupt outputs.
	a_idle_irq: assert property (@(posedge core_clk_i) disable iff (rst_i)
		idle_expire_i != 8'h00 |=> status_summary_o && mgmt_interrupt_o)
		else $error("idle expiry raised no interrupt");
	a_video_irq: assert property (@(posedge core_clk_i) disable iff (rst_i)
		video_trap_i |=> mgmt_interrupt_o)
		else $error("video trap raised no interrupt");
	a_sw_pulse_once: assert property (@(posedge core_clk_i) disable iff (rst_i)
		sw_trigger_pulse_o |=> !sw_trigger_pulse_o)
		else $error("software trigger pulse too long");

	c_sw_trigger: cover property (@(posedge core_clk_i) disable iff (rst_i) wr_sw);
	c_stat_clear: cover property (@(posedge core_clk_i) disable iff (rst_i)
		rd_stat2 && stat2_r != 8'h00);
	c_udev_hit: cover property (@(posedge core_clk_i) disable iff (rst_i) |hit_nxt);
	c_game_evt: cover property (@(posedge core_clk_i) disable iff (rst_i) game_evt);
	c_gpio_evt: cover property (@(posedge core_clk_i) disable iff (rst_i) |gpio_evt);

endmodule

// ==== bench/pm_host_snoop.sv ====
// Host bus model that presents one snooped bus cycle for each request.
`timescale 1ns/1ps

module pm_host_snoop
	import pm_trap_pkg::*;
(
	// Clock and reset
	input  wire logic         core_clk_i,
	input  wire logic         rst_i,
	// Request from the bench
	input  wire logic         go_i,
	input  wire snoop_cycle_t cyc_i,
	// Snooped cycle toward the block
	output snoop_cycle_t      snoop_o
);
	// Between cycles the address keeps toggling, so a stale match cannot pass for a hit.
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			snoop_o <= '0;
		end else if (go_i) begin
			snoop_o       <= cyc_i;
			snoop_o.valid <= 1'b1;
		end else begin
			snoop_o.valid <= 1'b0;
			snoop_o.addr  <= ~snoop_o.addr;
		end
	end
endmodule

// ==== bench/pm_trap_and_smi_status_test.sv ====
// Self-checking bench for the trap decode and status register slice.
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin err_count++; \
	$display("[ERR] %s expected %h seen %h", nm, ex, gt); end end

module pm_trap_and_smi_status_test;
	import pm_trap_pkg::*;
	logic         core_clk_i = 1'b0;
	logic         rst_i = 1'b1;
	logic         go = 1'b0;
	logic [9:0]   avs_address_i = '0;
	logic         avs_read_i = 1'b0;
	logic         avs_write_i = 1'b0;
	logic [31:0]  avs_writedata_i = '0;
	logic [31:0]  avs_readdata_o, rd;
	logic [31:0]  base [3];
	logic [3:0]   gpio_pin_i = '0;
	logic         avs_waitrequest_o, mgmt_interrupt_o, sw_trigger_pulse_o, status_summary_o;
	logic         video_trap_i = 1'b0;
	logic [7:0]   idle_expire_i = '0;
	logic [7:0]   timer_test_value_o, v;
	logic [7:0]   ctl [3];
	logic [11:0]  cfg;
	logic [2:0]   udev_hit_o, hx;
	snoop_cycle_t snoop_i, sc;
	snoop_cycle_t cyc = '0;
	int           err_count = 0, compares = 0, cycles = 0, n;
	int           seed = 32'h4195;
	logic [7:0]   ridx [14] = '{8'hcc, 8'hcd, 8'hce, 8'hd0, 8'hec, 8'hf4, 8'hf5, 8'hf6,
		8'h84, 8'h85, 8'h86, 8'hc0, 8'hc4, 8'hc8};
	logic [7:0]   corner [6] = '{8'h60, 8'h40, 8'h20, 8'h7f, 8'h80, 8'hff};
	logic [31:0]  pick [5] = '{32'h0, 32'h1f, 32'h1ff, 32'hfe00, 32'h10020};

	pm_trap_and_smi_status dut_u (.core_clk_i(core_clk_i), .rst_i(rst_i),
		.avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
		.avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hf),
		.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
		.snoop_i(snoop_i), .idle_expire_i(idle_expire_i), .video_trap_i(video_trap_i),
		.gpio_pin_i(gpio_pin_i), .udev_hit_o(udev_hit_o), .mgmt_interrupt_o(mgmt_interrupt_o),
		.sw_trigger_pulse_o(sw_trigger_pulse_o), .status_summary_o(status_summary_o),
		.timer_test_value_o(timer_test_value_o));

	pm_host_snoop host_u (.core_clk_i(core_clk_i), .rst_i(rst_i), .go_i(go), .cyc_i(cyc),
		.snoop_o(snoop_i));

	always #5 core_clk_i = ~core_clk_i;

	// -------------------------------------------------------------
	// Shared tasks and reference functions
	// -------------------------------------------------------------
	task automatic results();
		$display("Comparisons %0d, mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	// A hang in the sequence ends here as a mismatch; a stuck bus handshake is counted by the bus task after 20 cycles.
	always @(posedge core_clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			results();
		end
	end

	task automatic bus(input logic wr, input logic [7:0] i, input logic [31:0] d,
		output logic [31:0] q);
		int k;
		logic w;
		@(posedge core_clk_i);
		avs_address_i <= {i, 2'b00};
		avs_read_i <= !wr;
		avs_write_i <= wr;
		avs_writedata_i <= d;
		k = 0;
		w = 1'b1;
		while (w && k < 20) begin
			@(posedge core_clk_i);
			w = (avs_waitrequest_o !== 1'b0);
			q = avs_readdata_o;
			k++;
		end
		if (w) err_count++;
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
	endtask

	task automatic rchk(input logic [7:0] i, input logic [31:0] e);
		bus(1'b0, i, 32'h0, rd);
		`CHK("readdata", e, rd)
	endtask

	function automatic logic hit_exp(logic [31:0] b, logic [7:0] c, snoop_cycle_t s);
		logic [31:0] m;
		if (c[7]) begin
			m = {16'h0, c[6:0], 9'h1ff};
			return s.is_mem && (((s.addr ^ b) & ~m) == 32'h0);
		end
		m = {27'h0, c[4:0]};
		return !s.is_mem && (s.is_write ? c[6] : c[5]) && (((s.addr ^ b) & ~m) == 32'h0);
	endfunction

	task automatic snoop(input snoop_cycle_t s);
		@(posedge core_clk_i);
		go <= 1'b1;
		cyc <= s;
		@(posedge core_clk_i);
		go <= 1'b0;
		@(posedge core_clk_i);
		#1;
		for (int d = 0; d < 3; d++) hx[d] = hit_exp(base[d], ctl[d], s);
		`CHK("udev_hit", hx, udev_hit_o)
		@(posedge core_clk_i);
		#1;
		`CHK("udev_hit_end", 3'b000, udev_hit_o)
	endtask

	initial begin
		for (int d = 0; d < 3; d++) begin
			base[d] = '0;
			ctl[d] = '0;
		end
		repeat (6) @(posedge core_clk_i);
		rst_i <= 1'b0;
		foreach (ridx[k]) rchk(ridx[k], 32'h0);
		bus(1'b1, 8'h10, 32'hffff_ffff, rd);
		rchk(8'h10, UNMAPPED_DATA);
		v = $random(seed);
		bus(1'b1, IDX_TIMER_TEST, {24'h0, v}, rd);
		rchk(IDX_TIMER_TEST, {24'h0, v});
		`CHK("timer_out", v, timer_test_value_o)
		for (int k = 0; k < 2; k++) begin
			bus(1'b1, IDX_SW_TRIGGER, k ? $random(seed) : 32'h0, rd);
			n = 0;
			hx[0] = 1'b1;
			#1;
			repeat (4) begin
				if (sw_trigger_pulse_o === 1'b1) n++;
				if (sw_trigger_pulse_o === 1'b1) hx[0] = hx[0] & (mgmt_interrupt_o === 1'b1);
				@(posedge core_clk_i);
				#1;
			end
			`CHK("sw_pulse_count", 1, n)
			`CHK("sw_irq", 1'b1, hx[0])
		end
		rchk(IDX_SW_TRIGGER, 32'h0);
		for (int k = 0; k < 60; k++) begin
			n = {$random(seed)} % 3;
			base[n] = $random(seed);
			ctl[n] = (k < 6) ? corner[k] : 8'($random(seed));
			bus(1'b1, IDX_UDEV1_BASE + 8'(4 * n), base[n], rd);
			bus(1'b1, IDX_UDEV1_CTRL + 8'(n), {24'h0, ctl[n]}, rd);
			rchk(IDX_UDEV1_CTRL + 8'(n), {24'h0, ctl[n]});
			rchk(IDX_UDEV1_BASE + 8'(4 * n), base[n]);
			repeat (3) begin
				sc.addr = base[n] ^ (32'($random(seed)) & pick[{$random(seed)} % 5]);
				sc.is_mem = $random(seed);
				sc.is_write = $random(seed);
				sc.valid = 1'b1;
				snoop(sc);
			end
		end
		for (int k = 0; k < 8; k++) begin
			bus(1'b1, IDX_GAME_ENABLE, {30'h0, k[1:0]}, rd);
			sc = '{1'b1, 1'b0, k[2], {16'($random(seed)), 15'h100, 1'($random(seed))}};
			snoop(sc);
			v = {3'h0, k[2] ? k[1] : k[0], 4'h0};
			rchk(IDX_STAT1_MIRROR, {24'h0, v});
			rchk(IDX_STAT1, {24'h0, v});
			rchk(IDX_STAT1, 32'h0);
		end
		for (int k = 0; k < 6; k++) begin
			v = k ? 8'($random(seed)) : 8'hff;
			@(posedge core_clk_i);
			idle_expire_i <= v;
			video_trap_i <= k[0];
			@(posedge core_clk_i);
			idle_expire_i <= 8'h0;
			video_trap_i <= 1'b0;
			@(posedge core_clk_i);
			#1;
			`CHK("summary", 1'(|v || k[0]), status_summary_o)
			`CHK("irq", 1'(|v || k[0]), mgmt_interrupt_o)
			rchk(IDX_STAT2_MIRROR, {24'h0, v});
			rchk(IDX_STAT3_MIRROR, {24'h0, k[0], 7'h0});
			rchk(IDX_STAT2, {24'h0, v});
			rchk(IDX_STAT3, {24'h0, k[0], 7'h0});
			rchk(IDX_STAT2, 32'h0);
			#1;
			`CHK("summary_clear", 1'b0, status_summary_o)
		end
		for (int p = 0; p < 4; p++) begin
			for (int j = 0; j < 4; j++) begin
				cfg = 12'hfff;
				if (j != 0) cfg[(j - 1) * 4 + p] = 1'b0;
				bus(1'b1, IDX_GPIO_CONFIG, {20'h0, cfg}, rd);
				@(posedge core_clk_i);
				gpio_pin_i[p] <= ~gpio_pin_i[p];
				repeat (8) @(posedge core_clk_i);
				rchk(IDX_STAT1, {28'h0, 4'(j == 0) << p});
			end
		end
		results();
	end
endmodule
